//--- design/nvsram_soft_sequence_control.sv
// Purpose: host side engine that issues nonvolatile soft sequences
// Assumes: exclusive ownership of the memory bus during a sequence
// Notes:   no plain data transfers; host waits out store and recall
//
// What this block does
// - six reads ending 0x8FC0 start store
// - five leading reads then 0x4C63 recall
// - five leading reads then 0x8B45 disable autostore
// - five leading reads then 0x4B46 enable autostore
// - no other access between sequence reads
// - reads by chip enable, write enable high
// - host stores after autostore setting change
// - boot code rewrites desired config each powerup
`timescale 1ns/1ps
module nvsram_soft_sequence_control
#(
    parameter int ADDR_W      = 17,
    parameter int OP_WAIT_CYC = nvsram_seq_pkg::OP_WAIT_CYC
)
(
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_cmd_valid,
    input  wire logic [1:0]        i_cmd,
    output logic                   o_cmd_ready,
    output logic                   o_done,
    output logic [ADDR_W-1:0]      o_addr,
    output logic                   o_chip_en_n,
    output logic                   o_out_en_n,
    output logic                   o_write_en_n,
    output logic                   o_upper_byte_sel_n,
    output logic                   o_lower_byte_sel_n,
    input  wire logic              i_store_busy_n,
    output logic                   o_store_busy_n_out,
    output logic                   o_store_busy_n_oe_n
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            rst_sync_q <= 2'b00;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------
    // busy pin input
    // ------------------------------------------------------------
    logic busy_n;

    busy_sync u_busy_sync
    (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .i_async (i_store_busy_n),
        .o_level (busy_n)
    );

    // never pull the busy pin: that would request a hardware store
    assign o_store_busy_n_out  = 1'b1;
    assign o_store_busy_n_oe_n = 1'b1;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_LOW  = 2'b01,
        ST_HIGH = 2'b10,
        ST_WAIT = 2'b11
    } state_t;

    localparam logic [31:0] LOW_CYC  = 32'(nvsram_seq_pkg::READ_LOW_CYC);
    localparam logic [31:0] HIGH_CYC = 32'(nvsram_seq_pkg::READ_HIGH_CYC);
    localparam logic [31:0] WAIT_CYC = 32'(OP_WAIT_CYC);

    state_t      state_q;
    logic [2:0]  step_q;
    logic [1:0]  cmd_q;
    logic [31:0] cnt_q;
    logic [15:0] seq_addr;
    logic        last_step;
    logic        boot_q;

    assign last_step   = (step_q == 3'(nvsram_seq_pkg::SEQ_LEN - 1));
    assign o_cmd_ready = (state_q == ST_IDLE) && busy_n && !boot_q;

    // address for the current step; the full 16-bit code is driven
    // although the device only compares bits 14..2
    always_comb
    begin
        seq_addr = nvsram_seq_pkg::SEQ_ADDR_1;
        unique case (step_q)
            3'h0: seq_addr = nvsram_seq_pkg::SEQ_ADDR_1;
            3'h1: seq_addr = nvsram_seq_pkg::SEQ_ADDR_2;
            3'h2: seq_addr = nvsram_seq_pkg::SEQ_ADDR_3;
            3'h3: seq_addr = nvsram_seq_pkg::SEQ_ADDR_4;
            3'h4: seq_addr = nvsram_seq_pkg::SEQ_ADDR_5;
            default:
            begin
                unique case (cmd_q)
                    nvsram_seq_pkg::CMD_STORE:
                        seq_addr = nvsram_seq_pkg::SEQ_ADDR_STORE;
                    nvsram_seq_pkg::CMD_RECALL:
                        seq_addr = nvsram_seq_pkg::SEQ_ADDR_RECALL;
                    nvsram_seq_pkg::CMD_AS_OFF:
                        seq_addr = nvsram_seq_pkg::SEQ_ADDR_AS_OFF;
                    nvsram_seq_pkg::CMD_AS_ON:
                        seq_addr = nvsram_seq_pkg::SEQ_ADDR_AS_ON;
                endcase
            end
        endcase
    end

    // state, step and timer; nothing else can reach the bus between
    // reads, since commands are only taken in idle
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= ST_IDLE;
            step_q  <= 3'h0;
            cmd_q   <= 2'h0;
            cnt_q   <= 32'h0000_0000;
            o_done  <= 1'b0;
        end
        else
        begin
            o_done <= 1'b0;
            unique case (state_q)
                ST_IDLE:
                begin
                    // after reset the autostore setting is rewritten
                    // once before any command is taken
                    if (boot_q && busy_n)
                    begin
                        cmd_q   <= nvsram_seq_pkg::CMD_AS_ON;
                        step_q  <= 3'h0;
                        cnt_q   <= 32'h0000_0000;
                        state_q <= ST_LOW;
                    end
                    else if (i_cmd_valid && o_cmd_ready)
                    begin
                        cmd_q   <= i_cmd;
                        step_q  <= 3'h0;
                        cnt_q   <= 32'h0000_0000;
                        state_q <= ST_LOW;
                    end
                end
                ST_LOW:
                begin
                    if (cnt_q >= LOW_CYC - 32'h0000_0001)
                    begin
                        cnt_q   <= 32'h0000_0000;
                        state_q <= ST_HIGH;
                    end
                    else
                        cnt_q <= cnt_q + 32'h0000_0001;
                end
                ST_HIGH:
                begin
                    if (cnt_q >= HIGH_CYC - 32'h0000_0001)
                    begin
                        cnt_q <= 32'h0000_0000;
                        if (last_step)
                            state_q <= ST_WAIT;
                        else
                        begin
                            step_q  <= step_q + 3'h1;
                            state_q <= ST_LOW;
                        end
                    end
                    else
                        cnt_q <= cnt_q + 32'h0000_0001;
                end
                ST_WAIT:
                begin
                    // store/recall: wait the cycle time, then for the
                    // busy pin high; a config change is followed by a
                    // store, else the setting is lost at power down
                    if (cmd_q == nvsram_seq_pkg::CMD_AS_OFF ||
                        cmd_q == nvsram_seq_pkg::CMD_AS_ON)
                    begin
                        cmd_q   <= nvsram_seq_pkg::CMD_STORE;
                        step_q  <= 3'h0;
                        state_q <= ST_LOW;
                    end
                    else if (cnt_q < WAIT_CYC)
                        cnt_q <= cnt_q + 32'h0000_0001;
                    else if (busy_n)
                    begin
                        o_done  <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // boot rewrite pending; the filtered busy level reads high for a
    // few cycles after reset, so a power-up recall is not waited for
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
            boot_q <= 1'b1;
        else if (state_q == ST_IDLE && busy_n)
            boot_q <= 1'b0;
    end

    // ------------------------------------------------------------
    // bus pins
    // ------------------------------------------------------------
    // chip-enable timed reads, write enable held high
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_addr       <= '0;
            o_chip_en_n  <= 1'b1;
            o_out_en_n   <= 1'b1;
            o_write_en_n <= 1'b1;
        end
        else
        begin
            o_addr       <= ADDR_W'(seq_addr);
            o_chip_en_n  <= !(state_q == ST_LOW);
            o_out_en_n   <= !(state_q == ST_LOW);
            o_write_en_n <= 1'b1;
        end
    end

    // both byte lanes enabled; harmless on the byte-wide part
    assign o_upper_byte_sel_n = 1'b0;
    assign o_lower_byte_sel_n = 1'b0;

endmodule

//--- include/nvsram_seq_pkg.sv
// Purpose: shared constants for the nvsram soft sequence host controller
// Assumes: 40 MHz system clock
// Notes:   sequence addresses are given on a 16-bit address view
package nvsram_seq_pkg;

    // ------------------------------------------------------------
    // sequence addresses
    // ------------------------------------------------------------
    localparam logic [15:0] SEQ_ADDR_1       = 16'h4E38;
    localparam logic [15:0] SEQ_ADDR_2       = 16'hB1C7;
    localparam logic [15:0] SEQ_ADDR_3       = 16'h83E0;
    localparam logic [15:0] SEQ_ADDR_4       = 16'h7C1F;
    localparam logic [15:0] SEQ_ADDR_5       = 16'h703F;
    localparam logic [15:0] SEQ_ADDR_STORE   = 16'h8FC0;
    localparam logic [15:0] SEQ_ADDR_RECALL  = 16'h4C63;
    localparam logic [15:0] SEQ_ADDR_AS_OFF  = 16'h8B45;
    localparam logic [15:0] SEQ_ADDR_AS_ON   = 16'h4B46;
    localparam int          SEQ_LEN          = 6;

    // ------------------------------------------------------------
    // commands
    // ------------------------------------------------------------
    localparam logic [1:0] CMD_STORE  = 2'h0;
    localparam logic [1:0] CMD_RECALL = 2'h1;
    localparam logic [1:0] CMD_AS_OFF = 2'h2;
    localparam logic [1:0] CMD_AS_ON  = 2'h3;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS    = 25000;
    localparam int READ_LOW_NS      = 50;   // enable low time per read
    localparam int READ_HIGH_NS     = 25;   // enable high time between reads
    localparam int READ_LOW_CYC     =
        (READ_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int READ_HIGH_CYC    =
        (READ_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int OP_WAIT_US       = 8000; // default store/recall wait
    localparam int OP_WAIT_CYC      = OP_WAIT_US * 40;

endpackage

//--- design/busy_sync.sv
// Purpose: three-flop synchroniser for the store busy pin
// Assumes: input is asynchronous to i_clk
// Notes:   level valid once the second and third stages agree
`timescale 1ns/1ps
module busy_sync
(
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_async,
    output logic      o_level
);

    logic [2:0] sync_q;

    // first stage feeds only the second one
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            sync_q <= 3'b111;
        else
            sync_q <= {sync_q[1:0], i_async};
    end

    // filtered level only moves when the two late stages agree
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_level <= 1'b1;
        else if (sync_q[1] == sync_q[2])
            o_level <= sync_q[2];
    end

endmodule

//--- verification/seq_ctrl_props.sv
// Purpose: checker for the soft sequence host controller
// Assumes: reads are two cycles low and one cycle high
// Notes:   bound by module name below
`timescale 1ns/1ps
module seq_ctrl_props
#(
    parameter int ADDR_W = 17
)
(
    input wire logic              i_clk,
    input wire logic              i_rst_n,
    input wire logic              i_cmd_valid,
    input wire logic [1:0]        i_cmd,
    input wire logic              o_cmd_ready,
    input wire logic              o_done,
    input wire logic [ADDR_W-1:0] o_addr,
    input wire logic              o_chip_en_n,
    input wire logic              o_out_en_n,
    input wire logic              o_write_en_n,
    input wire logic              i_store_busy_n
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    // a read starts at the falling chip enable
    sequence rd(logic [15:0] a);
        $fell(o_chip_en_n) && o_addr == ADDR_W'(a);
    endsequence
    // reads two to five, each three cycles after the one before
    sequence rd_tail;
        rd(nvsram_seq_pkg::SEQ_ADDR_2) ##3 rd(nvsram_seq_pkg::SEQ_ADDR_3)
        ##3 rd(nvsram_seq_pkg::SEQ_ADDR_4) ##3 rd(nvsram_seq_pkg::SEQ_ADDR_5);
    endsequence
    // the sixth read picks the operation
    sequence rd_last;
        rd(nvsram_seq_pkg::SEQ_ADDR_STORE) or
        rd(nvsram_seq_pkg::SEQ_ADDR_RECALL) or
        rd(nvsram_seq_pkg::SEQ_ADDR_AS_OFF) or
        rd(nvsram_seq_pkg::SEQ_ADDR_AS_ON);
    endsequence
    order_walk_a: assert property (
        rd(nvsram_seq_pkg::SEQ_ADDR_1) |-> ##3 rd_tail)
        else $error("sequence order broken");
    sixth_pick_a: assert property (
        rd(nvsram_seq_pkg::SEQ_ADDR_5) |-> ##3 rd_last)
        else $error("bad sixth address");
    start_first_a: assert property (
        i_cmd_valid && o_cmd_ready |-> ##2 rd(nvsram_seq_pkg::SEQ_ADDR_1))
        else $error("sequence did not start");
    read_shape_a: assert property (
        $fell(o_chip_en_n) |=> !o_chip_en_n ##1 o_chip_en_n)
        else $error("read length wrong");
    we_high_a: assert property (
        o_write_en_n && o_out_en_n == o_chip_en_n)
        else $error("write enable or output enable wrong");
    // the busy filter needs four edges before ready can drop
    busy_hold_a: assert property (
        (!i_store_busy_n)[*5] |-> !o_cmd_ready && o_chip_en_n)
        else $error("access while busy");
    done_clean_a: assert property (
        o_done |-> o_chip_en_n ##1 !o_done)
        else $error("done pulse wrong");
    // a config change runs straight into a store sequence
    cfg_time_a: assert property (
        i_cmd_valid && o_cmd_ready && i_cmd[1]
        |-> ##20 !o_done ##1 rd(nvsram_seq_pkg::SEQ_ADDR_1))
        else $error("no store after config change");
endmodule
bind nvsram_soft_sequence_control seq_ctrl_props #(.ADDR_W(ADDR_W)) u_props (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid),
    .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready), .o_done(o_done),
    .o_addr(o_addr), .o_chip_en_n(o_chip_en_n), .o_out_en_n(o_out_en_n),
    .o_write_en_n(o_write_en_n), .i_store_busy_n(i_store_busy_n));

//--- verification/nvsram_dev_model.sv
// Purpose: behavioural memory device that decodes soft sequences
// Assumes: a read ends at the rising chip enable
// Notes:   only the busy pin, the outcome counters and the autostore flag are modelled
`timescale 1ns/1ps
module nvsram_dev_model
#(
    parameter int BUSY_CYC = 30
)
(
    input  wire logic        i_clk,
    input  wire logic [16:0] i_addr,
    input  wire logic        i_chip_en_n,
    input  wire logic        i_write_en_n,
    input  wire logic        i_supply_low,
    output logic             o_store_busy_n,
    output int               o_stores,
    output int               o_recalls,
    output logic             o_autostore
);
    localparam logic [15:0] SEQ [0:4] = '{nvsram_seq_pkg::SEQ_ADDR_1,
        nvsram_seq_pkg::SEQ_ADDR_2, nvsram_seq_pkg::SEQ_ADDR_3,
        nvsram_seq_pkg::SEQ_ADDR_4, nvsram_seq_pkg::SEQ_ADDR_5};
    int          step = 0;
    int          busy = 0;
    logic        ce_q = 1'b1;
    logic [12:0] k;
    initial o_stores = 0;
    initial o_recalls = 0;
    initial o_autostore = 1'b1;
    // decode on the end of each read; busy reads abort the walk
    always @(posedge i_clk)
    begin
        ce_q <= i_chip_en_n;
        if (busy > 0) busy <= busy - 1;
        if (!ce_q && i_chip_en_n)
        begin
            k = i_addr[14:2];
            if (!i_write_en_n || busy > 0) step <= 0;
            else if (step == 5 && !i_supply_low &&
                     k == nvsram_seq_pkg::SEQ_ADDR_STORE[14:2])
            begin
                o_stores <= o_stores + 1;
                busy <= BUSY_CYC;
                step <= 0;
            end
            else if (step == 5 && k == nvsram_seq_pkg::SEQ_ADDR_RECALL[14:2])
            begin
                o_recalls <= o_recalls + 1;
                step <= 0;
            end
            else if (step == 5 && k == nvsram_seq_pkg::SEQ_ADDR_AS_OFF[14:2])
            begin
                o_autostore <= 1'b0;
                step <= 0;
            end
            else if (step == 5 && k == nvsram_seq_pkg::SEQ_ADDR_AS_ON[14:2])
            begin
                o_autostore <= 1'b1;
                step <= 0;
            end
            else if (step < 5 && k == SEQ[step][14:2]) step <= step + 1;
            else step <= (k == SEQ[0][14:2]) ? 1 : 0;
        end
    end
    assign o_store_busy_n = (busy == 0);
endmodule

//--- verification/nvsram_soft_sequence_control_bench.sv
// Purpose: random and corner tests of the soft sequence controller
// Assumes: short operation wait of 20 cycles
// Notes:   bench pull-down on the busy wire tests refusal
`timescale 1ns/1ps
module nvsram_soft_sequence_control_bench;
    logic        i_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        i_cmd_valid = 1'b0;
    logic [1:0]  i_cmd = 2'h0;
    logic        pull_n = 1'b1;
    logic        ce_n, oe_n, we_n, done, ready, bo, boe_n, dev_busy, as_on;
    logic        ub_n, lb_n;
    logic        vcc_low = 1'b0;
    logic [16:0] addr;
    wire         busy_w = dev_busy & pull_n & (boe_n | bo);
    int          stores, recalls, error_cnt = 0, n_compared = 0;
    int          seed = 32'ha392b200;
    int          st_exp = 0;
    int          rc_exp = 0;
    logic        as_exp = 1'b1;
    always #12.5 i_clk = ~i_clk;
    nvsram_soft_sequence_control #(.OP_WAIT_CYC(20)) DUT (.i_clk(i_clk),
        .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
        .o_cmd_ready(ready), .o_done(done), .o_addr(addr),
        .o_chip_en_n(ce_n), .o_out_en_n(oe_n), .o_write_en_n(we_n),
        .o_upper_byte_sel_n(ub_n), .o_lower_byte_sel_n(lb_n),
        .i_store_busy_n(busy_w), .o_store_busy_n_out(bo),
        .o_store_busy_n_oe_n(boe_n));
    nvsram_dev_model u_dev (.i_clk(i_clk), .i_addr(addr), .i_chip_en_n(ce_n),
        .i_write_en_n(we_n), .o_store_busy_n(dev_busy), .o_stores(stores),
        .o_recalls(recalls), .o_autostore(as_on), .i_supply_low(vcc_low));
    // autostore state expected after a command
    function automatic logic exp_as(input logic cur, input logic [1:0] c);
        if (c == nvsram_seq_pkg::CMD_AS_OFF) return 1'b0;
        if (c == nvsram_seq_pkg::CMD_AS_ON) return 1'b1;
        return cur;
    endfunction
    // stores expected: a store, or the one chained to a config change,
    // none while the supply is low
    function automatic int exp_st(input logic [1:0] c, input logic low);
        if (low) return 0;
        if (c == nvsram_seq_pkg::CMD_RECALL) return 0;
        return 1;
    endfunction
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1)
        begin
            error_cnt++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    // bounded wait for ready (sel low) or done (sel high); a lapse
    // ends the run
    task automatic wait_hi(input logic sel, input int lim);
        int n;
        n = 0;
        while ((sel ? done : ready) !== 1'b1 && n < lim)
        begin
            @(posedge i_clk);
            #2;
            n++;
        end
        if ((sel ? done : ready) !== 1'b1)
        begin
            check(1'b0, "wait timed out");
            results();
        end
    endtask
    // one command from request to done, then compare outcomes
    task automatic run(input logic [1:0] c);
        wait_hi(1'b0, 100);
        i_cmd = c;
        i_cmd_valid = 1'b1;
        @(posedge i_clk);
        #2;
        i_cmd_valid = 1'b0;
        wait_hi(1'b1, 200);
        st_exp += exp_st(c, vcc_low);
        rc_exp += (c == nvsram_seq_pkg::CMD_RECALL);
        as_exp = exp_as(as_exp, c);
        check(stores == st_exp, "store count");
        check(recalls == rc_exp, "recall count");
        check(as_on === as_exp, "autostore state");
        check(ub_n === 1'b0 && lb_n === 1'b0, "byte selects");
        check(boe_n === 1'b1, "busy pin driven");
        $display("test cmd %0d done", c);
    endtask
    initial
    begin
        repeat (16) @(posedge i_clk);
        #2;
        i_rst_n = 1'b1;
        check(as_on === 1'b1, "autostore default");
        // the boot rewrite ends in a store before ready rises
        wait_hi(1'b0, 300);
        check(stores == 1 && as_on === 1'b1, "boot rewrite");
        st_exp = 1;
        $display("test boot done");
        for (int i = 0; i < 4; i++) run(2'(i));
        for (int i = 0; i < 10; i++) run(2'($random(seed)));
        // refusal: busy pulled low while a request is raised
        wait_hi(1'b0, 100);
        pull_n = 1'b0;
        repeat (5) @(posedge i_clk);
        #2;
        i_cmd_valid = 1'b1;
        repeat (8) @(posedge i_clk);
        #2;
        check(ready === 1'b0 && ce_n === 1'b1, "ran while busy");
        i_cmd_valid = 1'b0;
        pull_n = 1'b1;
        check(stores == st_exp, "refused command ran");
        $display("test refusal done");
        // low supply: the sequence runs but no store may follow
        vcc_low = 1'b1;
        run(nvsram_seq_pkg::CMD_STORE);
        vcc_low = 1'b0;
        run(nvsram_seq_pkg::CMD_STORE);
        results();
    end
endmodule
